// ===== hw/tsc_map.vh
// Register map, field positions and timing constants of the tape step controller.
// Assumes a 10 MHz system clock; included by the controller and the bench by bare name.
`ifndef TSC_MAP_VH
`define TSC_MAP_VH

// ==========================================================
// Register byte offsets
`define TSC_ADDR_W 8
`define TSC_REG_CTRL 8'h00
`define TSC_REG_STEP 8'h04
`define TSC_REG_STAT 8'h08
`define TSC_REG_CHARS 8'h0C

// ==========================================================
// Control fields
`define TSC_CTRL_W 6
`define TSC_CTRL_RST 6'h00
`define TSC_CTRL_SUPPLY 0
`define TSC_CTRL_STEP 1
`define TSC_CTRL_GATE 2
`define TSC_CTRL_RUN 3
`define TSC_CTRL_MODE_LO 4
`define TSC_CTRL_MODE_HI 5

// ==========================================================
// Motion modes
`define TSC_MODE_LEVEL 2'h0
`define TSC_MODE_OPEN 2'h1
`define TSC_MODE_CLOSED 2'h2

// ==========================================================
// Status fields
`define TSC_STAT_SPROCKET 0
`define TSC_STAT_BUSY 1
`define TSC_STAT_VALID 2
`define TSC_STAT_BYTE_LO 8
`define TSC_STAT_BYTE_HI 15

// ==========================================================
// Widths and reset values
`define TSC_CNT_W 16
`define TSC_CNT_RST 16'h0000
`define TSC_BYTE_RST 8'h00
`define TSC_DATA_W 8

// ==========================================================
// Timing
`define TSC_CLK_NS 100
`define TSC_PULSE_NS 5000
`define TSC_PULSE_CYC ((`TSC_PULSE_NS + `TSC_CLK_NS - 1) / `TSC_CLK_NS)
`define TSC_OPEN_RATE_CPS 60
`define TSC_OPEN_PERIOD_NS ((1000000000 + `TSC_OPEN_RATE_CPS - 1) / `TSC_OPEN_RATE_CPS)
`define TSC_OPEN_PERIOD_CYC ((`TSC_OPEN_PERIOD_NS + `TSC_CLK_NS - 1) / `TSC_CLK_NS)
`define TSC_PER_W 18

`endif

// ===== hw/tsc_sync.v
// Two-stage synchroniser with rising-edge detect for the reader's pin outputs.
// Assumes asynchronous pin levels and an already synchronised active-low reset.
`timescale 1ns/10ps
module tsc_sync #(
  parameter WIDTH = 9
) (
  // Clock and reset
  input wire clk,
  input wire rstN,
  // Pins in
  input wire [WIDTH-1:0] din,
  // Synchronised out
  output wire [WIDTH-1:0] dout,
  output wire [WIDTH-1:0] rise
);

  // ==========================================================
  // Per-bit stages
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : gBit
      reg s1_q;
      reg s2_q;
      reg s3_q;
      always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
        end else begin
          s1_q <= din[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end
      assign dout[i] = s2_q;
      assign rise[i] = s2_q & ~s3_q;
    end
  endgenerate

endmodule

// ===== hw/tsc_ctrl.v
// Controller that drives a perforated-tape reader's run/stop line and option links.
// Assumes APB access from software and reader pins asynchronous to clk_sys.
`timescale 1ns/10ps
`include "tsc_map.vh"
module tsc_ctrl #(
  parameter PULSE_CYC = `TSC_PULSE_CYC,
  parameter OPEN_PERIOD_CYC = `TSC_OPEN_PERIOD_CYC,
  parameter DATA_W = `TSC_DATA_W
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // APB slave
  input wire [`TSC_ADDR_W-1:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Reader outputs
  input wire sprocketHole,
  input wire [DATA_W-1:0] dataChannel,
  // Reader inputs
  output wire runRequest,
  output wire stepLinkClosed,
  output wire gateLinkClosed,
  output wire supplyLinkClosed
);

  // ==========================================================
  // States
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_PULSE = 2'b01;
  localparam [1:0] ST_WAIT = 2'b10;
  localparam integer PULSE_LAST_I = PULSE_CYC - 1;
  localparam integer PERIOD_LAST_I = OPEN_PERIOD_CYC - 1;
  localparam [`TSC_PER_W-1:0] PULSE_LAST = PULSE_LAST_I[`TSC_PER_W-1:0];
  localparam [`TSC_PER_W-1:0] PERIOD_LAST = PERIOD_LAST_I[`TSC_PER_W-1:0];

  // ==========================================================
  // Register index decode
  function [2:0] regSel;
    input [`TSC_ADDR_W-1:0] a;
    begin
      case (a)
        `TSC_REG_CTRL: regSel = 3'h1;
        `TSC_REG_STEP: regSel = 3'h2;
        `TSC_REG_STAT: regSel = 3'h3;
        `TSC_REG_CHARS: regSel = 3'h4;
        default: regSel = 3'h0;
      endcase
    end
  endfunction

  // ==========================================================
  // Reset release
  reg rstSync1_q;
  reg rstSync2_q;
  wire rstInt_n;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rstSync1_q <= 1'b0;
      rstSync2_q <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rstSync2_q <= rstSync1_q;
    end
  end
  assign rstInt_n = rstSync2_q;

  // ==========================================================
  // Pin synchronisers
  wire [DATA_W:0] pinSync;
  wire [DATA_W:0] pinRise;
  wire sprocketLvl;
  wire sprocketEdge;

  tsc_sync #(
    .WIDTH(DATA_W + 1)
  ) uSync (
    .clk(clk_sys),
    .rstN(rstInt_n),
    .din({sprocketHole, dataChannel}),
    .dout(pinSync),
    .rise(pinRise)
  );
  assign sprocketLvl = pinSync[DATA_W];

  // ==========================================================
  // Edge arming
  // Hole already under the head at reset release is no new character
  reg [2:0] edgeArm_q;

  always @(posedge clk_sys or negedge rstInt_n) begin
    if (!rstInt_n) begin
      edgeArm_q <= 3'h0;
    end else begin
      edgeArm_q <= {edgeArm_q[1:0], 1'b1};
    end
  end
  assign sprocketEdge = pinRise[DATA_W] & edgeArm_q[2];

  // ==========================================================
  // Register storage
  reg [`TSC_CTRL_W-1:0] ctrl_q;
  reg [`TSC_CNT_W-1:0] steps_q;
  reg [`TSC_CNT_W-1:0] steps_d;
  reg [`TSC_CNT_W-1:0] chars_q;
  reg [DATA_W-1:0] byte_q;
  reg valid_q;
  reg [31:0] prdata_q;
  reg pslverr_q;
  wire [1:0] mode;
  wire setupPh;
  wire wrEn;
  wire [2:0] sel;
  wire stepWr;
  wire validClr;

  assign mode = ctrl_q[`TSC_CTRL_MODE_HI:`TSC_CTRL_MODE_LO];
  assign setupPh = psel & ~penable;
  assign wrEn = psel & penable & pwrite;
  assign sel = regSel(paddr);
  assign stepWr = wrEn & (sel == 3'h2);
  assign validClr = wrEn & (sel == 3'h3) & pwdata[`TSC_STAT_VALID];

  // ==========================================================
  // Step engine
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`TSC_PER_W-1:0] pulseCnt_q;
  reg [`TSC_PER_W-1:0] pulseCnt_d;
  reg [`TSC_PER_W-1:0] perCnt_q;
  reg [`TSC_PER_W-1:0] perCnt_d;
  reg runReq_q;
  reg runReq_d;
  wire stepMode;
  wire nextDue;

  assign stepMode = (mode == `TSC_MODE_OPEN) | (mode == `TSC_MODE_CLOSED);
  // Closed loop: next pulse on the sprocket edge that stopped the reader
  assign nextDue = (mode == `TSC_MODE_CLOSED) ? sprocketEdge :
                   (perCnt_q == {`TSC_PER_W{1'b0}});

  always @* begin
    state_d = state_q;
    pulseCnt_d = pulseCnt_q;
    perCnt_d = perCnt_q;
    steps_d = steps_q;
    if (perCnt_q != {`TSC_PER_W{1'b0}}) begin
      perCnt_d = perCnt_q - 1'b1;
    end
    case (state_q)
      ST_IDLE: begin
        if (stepMode && steps_q != `TSC_CNT_RST && ctrl_q[`TSC_CTRL_SUPPLY]) begin
          state_d = ST_PULSE;
          pulseCnt_d = PULSE_LAST;
          perCnt_d = PERIOD_LAST;
        end
      end
      ST_PULSE: begin
        if (pulseCnt_q == {`TSC_PER_W{1'b0}}) begin
          state_d = ST_WAIT;
          steps_d = steps_q - 1'b1;
        end else begin
          pulseCnt_d = pulseCnt_q - 1'b1;
        end
      end
      ST_WAIT: begin
        if (nextDue) begin
          if (steps_q != `TSC_CNT_RST) begin
            state_d = ST_PULSE;
            pulseCnt_d = PULSE_LAST;
            perCnt_d = PERIOD_LAST;
          end else begin
            state_d = ST_IDLE;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (!stepMode) begin
      state_d = ST_IDLE;
    end
    if (stepWr) begin
      steps_d = pwdata[`TSC_CNT_W-1:0];
    end
  end

  // Request level: held in level mode, pulsed in step modes
  always @* begin
    if (!ctrl_q[`TSC_CTRL_SUPPLY]) begin
      runReq_d = 1'b0;
    end else if (mode == `TSC_MODE_LEVEL) begin
      runReq_d = ctrl_q[`TSC_CTRL_RUN];
    end else begin
      runReq_d = (state_d == ST_PULSE);
    end
  end

  always @(posedge clk_sys or negedge rstInt_n) begin
    if (!rstInt_n) begin
      state_q <= ST_IDLE;
      pulseCnt_q <= {`TSC_PER_W{1'b0}};
      perCnt_q <= {`TSC_PER_W{1'b0}};
      steps_q <= `TSC_CNT_RST;
      runReq_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pulseCnt_q <= pulseCnt_d;
      perCnt_q <= perCnt_d;
      steps_q <= steps_d;
      runReq_q <= runReq_d;
    end
  end

  // ==========================================================
  // Character capture
  always @(posedge clk_sys or negedge rstInt_n) begin
    if (!rstInt_n) begin
      byte_q <= `TSC_BYTE_RST;
      valid_q <= 1'b0;
      chars_q <= `TSC_CNT_RST;
    end else begin
      if (sprocketEdge) begin
        byte_q <= pinSync[DATA_W-1:0];
        valid_q <= 1'b1;
        chars_q <= chars_q + 1'b1;
      end else if (validClr) begin
        valid_q <= 1'b0;
      end
      if (wrEn && sel == 3'h4) begin
        chars_q <= `TSC_CNT_RST;
      end
    end
  end

  // ==========================================================
  // APB control register and read path
  reg [31:0] rdMux;

  always @* begin
    rdMux = 32'h00000000;
    case (sel)
      3'h1: rdMux[`TSC_CTRL_W-1:0] = ctrl_q;
      3'h2: rdMux[`TSC_CNT_W-1:0] = steps_q;
      3'h3: begin
        rdMux[`TSC_STAT_SPROCKET] = sprocketLvl;
        rdMux[`TSC_STAT_BUSY] = (state_q != ST_IDLE);
        rdMux[`TSC_STAT_VALID] = valid_q;
        rdMux[`TSC_STAT_BYTE_HI:`TSC_STAT_BYTE_LO] = byte_q;
      end
      3'h4: rdMux[`TSC_CNT_W-1:0] = chars_q;
      default: rdMux = 32'h00000000;
    endcase
  end

  always @(posedge clk_sys or negedge rstInt_n) begin
    if (!rstInt_n) begin
      ctrl_q <= `TSC_CTRL_RST;
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else begin
      if (setupPh) begin
        prdata_q <= pwrite ? 32'h00000000 : rdMux;
        pslverr_q <= (sel == 3'h0);
      end
      if (wrEn && sel == 3'h1) begin
        ctrl_q <= pwdata[`TSC_CTRL_W-1:0];
      end
    end
  end

  // ==========================================================
  // Outputs
  assign prdata = prdata_q;
  assign pready = psel & penable;
  assign pslverr = psel & penable & pslverr_q;
  assign runRequest = runReq_q;
  assign stepLinkClosed = ctrl_q[`TSC_CTRL_STEP];
  assign gateLinkClosed = ctrl_q[`TSC_CTRL_GATE];
  assign supplyLinkClosed = ctrl_q[`TSC_CTRL_SUPPLY];

endmodule

// ===== tb/tsc_reader_model.sv
// Tape reader model: drive logic, sprocket and data outputs.
// Assumes one clk_sys tick moves the tape one step while running.
`timescale 1ns/10ps
module tsc_reader_model #(
  parameter CHAR = 40,
  parameter HOLE = 10,
  parameter PRESET = 20
) (
  // Clock
  input wire clk_sys,
  // Control pins
  input wire runRequest,
  input wire stepLinkClosed,
  input wire gateLinkClosed,
  input wire supplyLinkClosed,
  // Reader outputs
  output wire sprocketHole,
  output wire [7:0] dataChannel,
  output wire pinchOn,
  output wire brakeOn
);
  int pos = 0;
  int preCnt = 0;
  wire leg;
  wire run;
  wire [7:0] holes;
  wire lead;
  logic holeQ = 1'b1;
  logic stepRun = 1'b0;
  // =====
  // Drive
  always @(posedge clk_sys) begin
    if (preCnt < PRESET) preCnt <= preCnt + 1;
    if (pinchOn) pos <= pos + 1;
    holeQ <= sprocketHole;
    if (runRequest) stepRun <= 1'b1;
    else if (lead) stepRun <= 1'b0;
  end
  // Step leg holds motion until the next hole leading edge
  assign lead = sprocketHole && !holeQ;
  assign leg = stepLinkClosed && stepRun && !lead;
  assign run = preCnt >= PRESET && (runRequest || leg);
  assign pinchOn = supplyLinkClosed && run;
  assign brakeOn = supplyLinkClosed && !run;
  // =====
  // Read
  assign sprocketHole = pos % CHAR < HOLE;
  assign holes = 8'(pos / CHAR) * 8'h1D + 8'h35;
  assign dataChannel = gateLinkClosed ? holes & {8{sprocketHole}} : holes;
endmodule

// ===== tb/tsc_ctrl_sva.sv
// Checker on the controller's APB and reader pins.
// Assumes it is bound into tsc_ctrl and sees only its ports.
`timescale 1ns/10ps
module tsc_ctrl_sva #(
  parameter PULSE_CYC = 50
) (
  input wire clk_sys,
  input wire rst_n,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire runRequest,
  input wire stepLinkClosed,
  input wire gateLinkClosed,
  input wire supplyLinkClosed
);
  wire acc;
  wire bad;
  wire ctlWr;
  int hiCnt;
  assign acc = psel && penable;
  assign bad = paddr > 8'h0C || paddr[1:0] != 2'h0;
  assign ctlWr = acc && pwrite && paddr == 8'h00;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) hiCnt <= 0;
    else hiCnt <= runRequest ? hiCnt + 1 : 0;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // =====
  // Assertions
  AST_PREADY: assert property (pready == acc)
    else $error("pready wrong");
  AST_SLVERR: assert property (pslverr == (acc && bad))
    else $error("pslverr wrong");
  AST_ERR_ZERO: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  AST_CTRL_TOP: assert property (ctlWr || !acc || pwrite || paddr != 8'h00 || prdata[31:6] == 0)
    else $error("ctrl upper bits set");
  AST_SUPPLY: assert property (!supplyLinkClosed [*2] |-> !runRequest)
    else $error("run without supply");
  AST_PULSE: assert property (
    $fell(runRequest) && stepLinkClosed |-> hiCnt == PULSE_CYC)
    else $error("step pulse width");
  AST_GATE_WR: assert property (
    $changed(gateLinkClosed) |-> $past(ctlWr) || $past(ctlWr, 2))
    else $error("gate link moved without write");
  AST_RST_QUIET: assert property ($rose(rst_n) |-> !runRequest ##1 !runRequest)
    else $error("run soon after reset");
  cover property ($fell(runRequest) && stepLinkClosed);
  cover property (pslverr);
  cover property ($changed(gateLinkClosed));
endmodule
bind tsc_ctrl tsc_ctrl_sva #(.PULSE_CYC(PULSE_CYC)) u_sva (
  .clk_sys(clk_sys),
  .rst_n(rst_n),
  .paddr(paddr),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .runRequest(runRequest),
  .stepLinkClosed(stepLinkClosed),
  .gateLinkClosed(gateLinkClosed),
  .supplyLinkClosed(supplyLinkClosed)
);

// ===== tb/tsc_ctrl_tb.sv
// Bench: APB tasks drive the controller against the reader model.
// Assumes the design files and tsc_map.vh are compiled first.
`timescale 1ns/10ps
`include "tsc_map.vh"
module tsc_ctrl_tb;
  localparam int PERIOD = 200;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic runSeen = 1'b0;
  logic [31:0] rd;
  wire [31:0] prdata;
  wire [7:0] dataChannel;
  wire pready, pslverr, sprocketHole, runRequest, pinchOn, brakeOn;
  wire stepLinkClosed, gateLinkClosed, supplyLinkClosed;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  int lastRise = 0;
  int riseGap = 0;
  // =====
  // Clock, design, reader
  always #50 clk_sys = ~clk_sys;
  tsc_ctrl #(.PULSE_CYC(4), .OPEN_PERIOD_CYC(PERIOD)) u_dut (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .sprocketHole(sprocketHole),
    .dataChannel(dataChannel),
    .runRequest(runRequest),
    .stepLinkClosed(stepLinkClosed),
    .gateLinkClosed(gateLinkClosed),
    .supplyLinkClosed(supplyLinkClosed)
  );
  tsc_reader_model u_rdr (
    .clk_sys(clk_sys),
    .runRequest(runRequest),
    .stepLinkClosed(stepLinkClosed),
    .gateLinkClosed(gateLinkClosed),
    .supplyLinkClosed(supplyLinkClosed),
    .sprocketHole(sprocketHole),
    .dataChannel(dataChannel),
    .pinchOn(pinchOn),
    .brakeOn(brakeOn)
  );
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    runSeen <= runRequest;
    if (runRequest && !runSeen) begin
      riseGap <= cyc - lastRise;
      lastRise <= cyc;
    end
  end
  // =====
  // Tasks
  task automatic close_out();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic e);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    chk({31'h0, pslverr}, {31'h0, e});
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      error_cnt++;
      close_out();
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 1'b0);
    chk(rd, exp);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      repeat (10) @(posedge clk_sys);
      apb(1'b0, `TSC_REG_STAT, 32'h0, 1'b0);
      n++;
    end while ((rd[1] || pinchOn) && n < 100);
    if (n >= 100) begin
      error_cnt++;
      close_out();
    end
  endtask
  // =====
  // Scenarios
  task automatic t_reset();
    rdchk(`TSC_REG_CTRL, 32'h0);
    rdchk(`TSC_REG_STEP, 32'h0);
    rdchk(`TSC_REG_STAT, 32'h1);
    rdchk(`TSC_REG_CHARS, 32'h0);
    apb(1'b1, 8'h10, 32'h1, 1'b1);
    apb(1'b0, 8'h06, 32'h0, 1'b1);
    chk(rd, 32'h0);
    chk({30'h0, pinchOn, brakeOn}, 32'h0);
  endtask
  task automatic t_level();
    apb(1'b1, `TSC_REG_CTRL, 32'h09, 1'b0);
    repeat (5) @(posedge clk_sys);
    chk({30'h0, pinchOn, brakeOn}, 32'h2);
    repeat (100) @(posedge clk_sys);
    apb(1'b1, `TSC_REG_CTRL, 32'h01, 1'b0);
    repeat (5) @(posedge clk_sys);
    chk({30'h0, pinchOn, brakeOn}, 32'h1);
    rdchk(`TSC_REG_CHARS, 32'h2);
    rdchk(`TSC_REG_STAT, 32'h6F04);
    apb(1'b1, `TSC_REG_CTRL, 32'h08, 1'b0);
    repeat (5) @(posedge clk_sys);
    chk({31'h0, runRequest}, 32'h0);
    rdchk(`TSC_REG_CTRL, 32'h08);
  endtask
  task automatic t_closed();
    apb(1'b1, `TSC_REG_CTRL, 32'h27, 1'b0);
    wait_idle();
    chk({29'h0, stepLinkClosed, gateLinkClosed, supplyLinkClosed}, 32'h7);
    apb(1'b1, `TSC_REG_CHARS, 32'h0, 1'b0);
    apb(1'b1, `TSC_REG_STEP, 32'h3, 1'b0);
    wait_idle();
    rdchk(`TSC_REG_CHARS, 32'h3);
    chk({30'h0, pinchOn, brakeOn}, 32'h1);
    chk(32'(riseGap < 60), 32'h1);
    rdchk(`TSC_REG_STAT, 32'hE305);
    apb(1'b1, `TSC_REG_STAT, 32'h4, 1'b0);
    rdchk(`TSC_REG_STAT, 32'hE301);
  endtask
  task automatic t_open();
    apb(1'b1, `TSC_REG_CTRL, 32'h13, 1'b0);
    apb(1'b1, `TSC_REG_CHARS, 32'h0, 1'b0);
    apb(1'b1, `TSC_REG_STEP, 32'h2, 1'b0);
    wait_idle();
    rdchk(`TSC_REG_CHARS, 32'h2);
    chk(32'(riseGap >= PERIOD), 32'h1);
    rdchk(`TSC_REG_STEP, 32'h0);
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_reset();
    t_level();
    t_closed();
    t_open();
    close_out();
  end
endmodule
